// File: rtl/asr_pkg.sv
// How it works
// RULE1 - Junction temperature reads as 16-bit unsigned, codes 0 to 32767 only.
// RULE2 - Temperature code tracks sensor calibration: about 100 at -40 C, 12000 at 160 C.
// RULE3 - Temperature-compensated X and Y readable as signed 16-bit registers.
// RULE4 - Angle-calculation X and Y include phase, gain and offset corrections.
// RULE5 - Computed angle reads as 16-bit unsigned, codes 0 to 32767 only.
// RULE6 - Output value register holds output drive code, 0 to 32767 only.
// RULE7 - Field magnitude is about 1.6 times root of X squared plus Y squared.
// RULE8 - Self tests fill a 16-bit diagnostic register; bits 15:6 and 2 reserved.
// RULE9 - Bit 5 set when running signal-processor self test fails.
// RULE10 - Bit 4 set when power-up memory self test fails.
// RULE11 - Bit 3 set when continuous program memory parity check fails.
// RULE12 - Bit 1 set while magnitude is above upper field threshold.
// RULE13 - Bit 0 set while magnitude is below lower field threshold.
// RULE14 - Programming rides on the output pin; no separate programming pin.
// RULE15 - Measurement registers are read-only; parameters come from programmable memory.
// RULE16 - Field range violation forces the output to the high clamp level.
// RULE17 - All diagnostic flags clear at power-up reset before self tests run.
package asr_pkg;
    localparam int              ASR_DATA_W       = 16;
    localparam int              ASR_ADDR_W       = 4;
    localparam int              ASR_ACC_W        = 19;
    localparam int              ASR_ITER         = 14;
    localparam int              ASR_GAIN_SHIFT   = 14;
    localparam int              ASR_PHASE_SHIFT  = 15;
    localparam int              ASR_MAG_SCALE    = 256;
    localparam int              ASR_SMAX         = 32767;
    localparam int              ASR_SMIN         = -32768;
    localparam int              ASR_UMAX         = 65535;
    localparam logic [15:0]     ASR_CODE_MASK    = 16'h7FFF;
    localparam logic [15:0]     ASR_CLAMP_HIGH   = 16'h7FFF;
    localparam logic [14:0]     ASR_ANGLE_HALF   = 15'h4000;

    // Register indices on the programming read path
    localparam logic [3:0]      ASR_IDX_TEMP     = 4'h0;
    localparam logic [3:0]      ASR_IDX_XCOMP    = 4'h1;
    localparam logic [3:0]      ASR_IDX_YCOMP    = 4'h2;
    localparam logic [3:0]      ASR_IDX_XANGLE   = 4'h3;
    localparam logic [3:0]      ASR_IDX_YANGLE   = 4'h4;
    localparam logic [3:0]      ASR_IDX_ANGLE    = 4'h5;
    localparam logic [3:0]      ASR_IDX_OUTPUT   = 4'h6;
    localparam logic [3:0]      ASR_IDX_MAG      = 4'h7;
    localparam logic [3:0]      ASR_IDX_FLAGS    = 4'h8;

    // Diagnostic bit positions
    localparam int              ASR_BIT_SM       = 5;
    localparam int              ASR_BIT_NVM      = 4;
    localparam int              ASR_BIT_ROM      = 3;
    localparam int              ASR_BIT_FIELD_TOO_HIGH_FLAG    = 1;
    localparam int              ASR_BIT_FIELD_TOO_LOW_FLAG    = 0;
    localparam logic [15:0]     ASR_FLAGS_RESET  = 16'h0000;

    // Arctangent of 2^-i, 32768 codes per full turn
    localparam logic [14:0]     ASR_ATAN [ASR_ITER] = '{
        15'h1000, 15'h0972, 15'h04FE, 15'h0289, 15'h0146, 15'h00A3, 15'h0051,
        15'h0029, 15'h0014, 15'h000A, 15'h0005, 15'h0003, 15'h0001, 15'h0001
    };

    typedef enum logic [1:0] {
        ASR_IDLE    = 2'b00,
        ASR_CORRECT = 2'b01,
        ASR_ROTATE  = 2'b11,
        ASR_FINISH  = 2'b10
    } asr_state_e;
endpackage : asr_pkg

// File: rtl/asr_readout.sv
`timescale 1ns/10ps
module asr_readout #(
    parameter int ITER = asr_pkg::ASR_ITER
) (
    input  wire logic                                    clk_sys,
    input  wire logic                                    rst,
    input  wire logic                                    sampleValid,
    input  wire logic        [asr_pkg::ASR_DATA_W-1:0]   tempSample,
    input  wire logic signed [asr_pkg::ASR_DATA_W-1:0]   xSample,
    input  wire logic signed [asr_pkg::ASR_DATA_W-1:0]   ySample,
    input  wire logic signed [asr_pkg::ASR_DATA_W-1:0]   offsetX,
    input  wire logic signed [asr_pkg::ASR_DATA_W-1:0]   offsetY,
    input  wire logic signed [asr_pkg::ASR_DATA_W-1:0]   gainX,
    input  wire logic signed [asr_pkg::ASR_DATA_W-1:0]   gainY,
    input  wire logic signed [asr_pkg::ASR_DATA_W-1:0]   phaseCorr,
    input  wire logic        [14:0]                      angleZero,
    input  wire logic signed [7:0]                       lowerFieldThreshold,
    input  wire logic signed [7:0]                       upperFieldThreshold,
    input  wire logic                                    stateMachineTestFail,
    input  wire logic                                    nvmTestDone,
    input  wire logic                                    nvmTestFail,
    input  wire logic                                    romParityFail,
    input  wire logic                                    progActive,
    input  wire logic                                    progRdReq,
    input  wire logic        [asr_pkg::ASR_ADDR_W-1:0]   progRdAddr,
    output logic             [asr_pkg::ASR_DATA_W-1:0]   progRdData,
    output logic                                         progRdValid,
    output logic             [asr_pkg::ASR_DATA_W-1:0]   outDrive,
    output logic                                         outDriveEn,
    output logic                                         busy
);
    import asr_pkg::*;

    localparam int CNT_W = $clog2(ITER + 1);

    function automatic logic signed [15:0] sat16(input logic signed [35:0] v);
        if (v > 36'(ASR_SMAX)) begin
            return 16'sh7FFF;
        end else if (v < 36'(ASR_SMIN)) begin
            return 16'sh8000;
        end
        return v[15:0];
    endfunction : sat16

    asr_state_e                  state_q, state_d;
    logic        [15:0]          temp_q, temp_d;
    logic signed [15:0]          xComp_q, xComp_d;
    logic signed [15:0]          yComp_q, yComp_d;
    logic signed [15:0]          xAngle_q, xAngle_d;
    logic signed [15:0]          yAngle_q, yAngle_d;
    logic signed [ASR_ACC_W-1:0] cx_q, cx_d;
    logic signed [ASR_ACC_W-1:0] cy_q, cy_d;
    logic        [14:0]          cz_q, cz_d;
    logic        [CNT_W-1:0]     iter_q, iter_d;
    logic        [15:0]          angle_q, angle_d;
    logic        [15:0]          mag_q, mag_d;
    logic        [15:0]          outVal_q, outVal_d;
    logic                        smFail_q, smFail_d;
    logic                        nvmFail_q, nvmFail_d;
    logic                        romFail_q, romFail_d;
    logic                        field_too_high_flag_q, field_too_high_flag_d;
    logic                        field_too_low_flag_q, field_too_low_flag_d;
    logic        [15:0]          rdData_q, rdData_d;
    logic                        rdValid_q, rdValid_d;

    logic signed [16:0]          offX;
    logic signed [16:0]          offY;
    logic signed [35:0]          prodX;
    logic signed [35:0]          prodY;
    logic signed [15:0]          corrX;
    logic signed [15:0]          corrY;
    logic signed [ASR_ACC_W-1:0] shX;
    logic signed [ASR_ACC_W-1:0] shY;
    logic        [15:0]          ampSat;
    int                          lowLimit;
    int                          highLimit;
    logic                        tooHigh;
    logic                        tooLow;
    logic        [15:0]          flags;

    // Signal path: correction, then iterative vectoring rotation
    always_comb begin
        state_d   = state_q;
        temp_d    = temp_q;
        xComp_d   = xComp_q;
        yComp_d   = yComp_q;
        xAngle_d  = xAngle_q;
        yAngle_d  = yAngle_q;
        cx_d      = cx_q;
        cy_d      = cy_q;
        cz_d      = cz_q;
        iter_d    = iter_q;
        angle_d   = angle_q;
        mag_d     = mag_q;
        outVal_d  = outVal_q;
        field_too_high_flag_d   = field_too_high_flag_q;
        field_too_low_flag_d   = field_too_low_flag_q;

        offX  = 17'(xComp_q) + 17'(offsetX);
        offY  = 17'(yComp_q) + 17'(offsetY);
        prodX = (36'(offX) * 36'(gainX)) >>> ASR_GAIN_SHIFT;
        prodY = ((36'(offY) * 36'(gainY)) >>> ASR_GAIN_SHIFT)
              + ((36'(offX) * 36'(phaseCorr)) >>> ASR_PHASE_SHIFT);
        corrX = sat16(prodX); // see RULE4
        corrY = sat16(prodY); // see RULE4
        shX   = cx_q >>> iter_q;
        shY   = cy_q >>> iter_q;

        // Raw accumulator gain of the rotation is about 1.647, kept on purpose
        if (cx_q > ASR_ACC_W'(ASR_UMAX)) begin
            ampSat = 16'hFFFF; // see RULE7
        end else begin
            ampSat = cx_q[15:0]; // see RULE7
        end
        lowLimit  = (lowerFieldThreshold < 0) ? -int'(lowerFieldThreshold) * ASR_MAG_SCALE
                                               : int'(lowerFieldThreshold) * ASR_MAG_SCALE;
        highLimit = ASR_SMAX - int'(upperFieldThreshold) * ASR_MAG_SCALE;
        tooHigh   = int'(ampSat) > highLimit;
        tooLow    = int'(ampSat) < lowLimit;

        unique case (state_q)
            ASR_IDLE: begin
                if (sampleValid) begin
                    temp_d  = tempSample & ASR_CODE_MASK; // see RULE1, RULE2
                    xComp_d = xSample; // see RULE3
                    yComp_d = ySample; // see RULE3
                    state_d = ASR_CORRECT;
                end
            end
            ASR_CORRECT: begin
                xAngle_d = corrX; // see RULE4
                yAngle_d = corrY; // see RULE4
                // Left half plane folded over so the rotation converges
                if (corrX < 0) begin
                    cx_d = -ASR_ACC_W'(corrX);
                    cy_d = -ASR_ACC_W'(corrY);
                    cz_d = ASR_ANGLE_HALF;
                end else begin
                    cx_d = ASR_ACC_W'(corrX);
                    cy_d = ASR_ACC_W'(corrY);
                    cz_d = '0;
                end
                iter_d  = '0;
                state_d = ASR_ROTATE;
            end
            ASR_ROTATE: begin
                if (cy_q >= 0) begin
                    cx_d = cx_q + shY;
                    cy_d = cy_q - shX;
                    cz_d = cz_q + ASR_ATAN[iter_q];
                end else begin
                    cx_d = cx_q - shY;
                    cy_d = cy_q + shX;
                    cz_d = cz_q - ASR_ATAN[iter_q];
                end
                iter_d = iter_q + CNT_W'(1);
                if (iter_q == CNT_W'(ITER - 1)) begin
                    state_d = ASR_FINISH;
                end
            end
            ASR_FINISH: begin
                angle_d = {1'b0, cz_q}; // see RULE5
                mag_d   = ampSat; // see RULE7
                field_too_high_flag_d = tooHigh; // see RULE12
                field_too_low_flag_d = tooLow; // see RULE13
                if (tooHigh || tooLow) begin
                    outVal_d = ASR_CLAMP_HIGH; // see RULE16
                end else begin
                    outVal_d = {1'b0, cz_q + angleZero} & ASR_CODE_MASK; // see RULE6
                end
                state_d = ASR_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_q  <= ASR_IDLE;
            temp_q   <= '0;
            xComp_q  <= '0;
            yComp_q  <= '0;
            xAngle_q <= '0;
            yAngle_q <= '0;
            cx_q     <= '0;
            cy_q     <= '0;
            cz_q     <= '0;
            iter_q   <= '0;
            angle_q  <= '0;
            mag_q    <= '0;
            outVal_q <= '0;
            field_too_high_flag_q  <= 1'b0;
            field_too_low_flag_q  <= 1'b0;
        end else begin
            state_q  <= state_d;
            temp_q   <= temp_d;
            xComp_q  <= xComp_d;
            yComp_q  <= yComp_d;
            xAngle_q <= xAngle_d;
            yAngle_q <= yAngle_d;
            cx_q     <= cx_d;
            cy_q     <= cy_d;
            cz_q     <= cz_d;
            iter_q   <= iter_d;
            angle_q  <= angle_d;
            mag_q    <= mag_d;
            outVal_q <= outVal_d;
            field_too_high_flag_q  <= field_too_high_flag_d;
            field_too_low_flag_q  <= field_too_low_flag_d;
        end
    end

    // Self-test flags stick until the next power-up
    always_comb begin
        smFail_d  = smFail_q | stateMachineTestFail; // see RULE9
        nvmFail_d = nvmFail_q | (nvmTestDone & nvmTestFail); // see RULE10
        romFail_d = romFail_q | romParityFail; // see RULE11
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            smFail_q  <= ASR_FLAGS_RESET[ASR_BIT_SM]; // see RULE17
            nvmFail_q <= ASR_FLAGS_RESET[ASR_BIT_NVM]; // see RULE17
            romFail_q <= ASR_FLAGS_RESET[ASR_BIT_ROM]; // see RULE17
        end else begin
            smFail_q  <= smFail_d;
            nvmFail_q <= nvmFail_d;
            romFail_q <= romFail_d;
        end
    end

    // Read-only access; no write path exists into the measurement set
    always_comb begin
        flags                = ASR_FLAGS_RESET; // see RULE8
        flags[ASR_BIT_SM]    = smFail_q;
        flags[ASR_BIT_NVM]   = nvmFail_q;
        flags[ASR_BIT_ROM]   = romFail_q;
        flags[ASR_BIT_FIELD_TOO_HIGH_FLAG] = field_too_high_flag_q;
        flags[ASR_BIT_FIELD_TOO_LOW_FLAG] = field_too_low_flag_q;
        rdValid_d            = progRdReq;
        rdData_d             = rdData_q;
        if (progRdReq) begin
            unique case (progRdAddr) // see RULE15
                ASR_IDX_TEMP:   rdData_d = temp_q;
                ASR_IDX_XCOMP:  rdData_d = xComp_q;
                ASR_IDX_YCOMP:  rdData_d = yComp_q;
                ASR_IDX_XANGLE: rdData_d = xAngle_q;
                ASR_IDX_YANGLE: rdData_d = yAngle_q;
                ASR_IDX_ANGLE:  rdData_d = angle_q;
                ASR_IDX_OUTPUT: rdData_d = outVal_q;
                ASR_IDX_MAG:    rdData_d = mag_q;
                ASR_IDX_FLAGS:  rdData_d = flags;
                default:        rdData_d = '0;
            endcase
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rdData_q  <= '0;
            rdValid_q <= 1'b0;
        end else begin
            rdData_q  <= rdData_d;
            rdValid_q <= rdValid_d;
        end
    end

    assign progRdData  = rdData_q;
    assign progRdValid = rdValid_q;
    assign outDrive    = outVal_q;
    // Driver released while the station modulates the shared output pin
    assign outDriveEn  = ~progActive; // see RULE14
    assign busy        = (state_q != ASR_IDLE);
endmodule : asr_readout

// File: verif/asr_readout_checker.sv
`timescale 1ns/10ps
module asr_readout_checker #(
    parameter int ITER = asr_pkg::ASR_ITER
) (
    input wire logic                            clk_sys,
    input wire logic                            rst,
    input wire logic                            stateMachineTestFail,
    input wire logic                            nvmTestDone,
    input wire logic                            nvmTestFail,
    input wire logic                            romParityFail,
    input wire logic                            progActive,
    input wire logic                            progRdReq,
    input wire logic [asr_pkg::ASR_ADDR_W-1:0]  progRdAddr,
    input wire logic [asr_pkg::ASR_DATA_W-1:0]  progRdData,
    input wire logic                            progRdValid,
    input wire logic [asr_pkg::ASR_DATA_W-1:0]  outDrive,
    input wire logic                            outDriveEn,
    input wire logic                            busy
);
    import asr_pkg::*;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    wire flagRd = progRdReq && (progRdAddr == ASR_IDX_FLAGS);
    wire codeRd = progRdReq && (progRdAddr == ASR_IDX_TEMP || progRdAddr == ASR_IDX_ANGLE
                                || progRdAddr == ASR_IDX_OUTPUT);

    a_read_answer: assert property (progRdReq |=> progRdValid) else $error("read not answered");
    a_valid_single: assert property (!progRdReq |=> !progRdValid) else $error("stray read valid");
    a_unmapped_zero: assert property (progRdReq && progRdAddr > 4'h8 |=> progRdData == 16'h0000)
        else $error("unmapped index not zero");
    a_reserved_zero: assert property (flagRd |=> (progRdData & 16'hFFC4) == 16'h0000)
        else $error("reserved flag bit set");
    a_code_range: assert property (codeRd |=> !progRdData[15])
        else $error("code above 32767");
    a_out_range: assert property (!outDrive[15]) else $error("output code above 32767");
    a_drive_enable: assert property (outDriveEn == !progActive) else $error("pin drive clash");
    a_sm_sticky: assert property (stateMachineTestFail ##1 flagRd |=> progRdData[5])
        else $error("state machine flag missing");
    a_nvm_flag: assert property (nvmTestDone && nvmTestFail ##1 flagRd |=> progRdData[4])
        else $error("memory test flag missing");
    a_rom_sticky: assert property (romParityFail ##1 flagRd |=> progRdData[3])
        else $error("parity flag missing");
    a_range_clamp: assert property (flagRd ##1 progRdData[1:0] != 2'b00 |-> outDrive == ASR_CLAMP_HIGH)
        else $error("range fault not clamped");

    cover property (flagRd ##1 progRdData[1:0] != 2'b00);
    cover property ($rose(busy));
    cover property (romParityFail ##1 flagRd);
endmodule : asr_readout_checker

bind asr_readout asr_readout_checker #(.ITER(ITER)) u_chk (
    .clk_sys(clk_sys), .rst(rst), .stateMachineTestFail(stateMachineTestFail), .nvmTestDone(nvmTestDone),
    .nvmTestFail(nvmTestFail), .romParityFail(romParityFail), .progActive(progActive), .progRdReq(progRdReq),
    .progRdAddr(progRdAddr), .progRdData(progRdData), .progRdValid(progRdValid), .outDrive(outDrive),
    .outDriveEn(outDriveEn), .busy(busy)
);

// File: verif/asr_station.sv
`timescale 1ns/10ps
module asr_station (
    input wire logic                            clk_sys,
    output logic                                progActive,
    output logic                                progRdReq,
    output logic [asr_pkg::ASR_ADDR_W-1:0]      progRdAddr,
    input wire logic [asr_pkg::ASR_DATA_W-1:0]  progRdData,
    input wire logic                            progRdValid
);
    import asr_pkg::*;
    initial begin
        progActive = 1'b0;
        progRdReq  = 1'b0;
        progRdAddr = 4'hF;
    end
    // Entered just after an edge; leaves just after an edge
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        int n;
        n = 0;
        progActive = 1'b1;
        progRdReq  = 1'b1;
        progRdAddr = a;
        @(posedge clk_sys);
        #1;
        progRdReq  = 1'b0;
        // Released address shows inverse, never a stale match
        progRdAddr = ~a;
        // Answer stands from the taking edge to the next; read it settled
        while (progRdValid !== 1'b1 && n < 4) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        d = (progRdValid === 1'b1) ? progRdData : 16'hxxxx;
        // Idle edge so a following request never rises where this one fell
        @(posedge clk_sys);
        #1;
    endtask : rd
    task automatic release_pin();
        progActive = 1'b0;
    endtask : release_pin
endmodule : asr_station

// File: verif/angle_sensor_readout_regs_tb_top.sv
`timescale 1ns/10ps
module angle_sensor_readout_regs_tb_top;
    import asr_pkg::*;
    logic               clk_sys, rst, sampleValid, stateMachineTestFail, nvmTestDone, nvmTestFail, romParityFail;
    logic [15:0]        tempSample, progRdData, outDrive, d;
    logic signed [15:0] xSample, ySample, offsetX, offsetY, gainX, gainY, phaseCorr;
    logic [14:0]        angleZero;
    logic signed [7:0]  lowerFieldThreshold, upperFieldThreshold;
    logic               progActive, progRdReq, progRdValid, outDriveEn, busy;
    logic [3:0]         progRdAddr;
    int                 badCount = 0;
    int                 checked = 0;

    always #20 clk_sys = ~clk_sys;

    asr_readout u_dut (.clk_sys(clk_sys), .rst(rst), .sampleValid(sampleValid), .tempSample(tempSample),
        .xSample(xSample), .ySample(ySample), .offsetX(offsetX), .offsetY(offsetY), .gainX(gainX), .gainY(gainY),
        .phaseCorr(phaseCorr), .angleZero(angleZero), .lowerFieldThreshold(lowerFieldThreshold),
        .upperFieldThreshold(upperFieldThreshold), .stateMachineTestFail(stateMachineTestFail),
        .nvmTestDone(nvmTestDone), .nvmTestFail(nvmTestFail), .romParityFail(romParityFail),
        .progActive(progActive), .progRdReq(progRdReq), .progRdAddr(progRdAddr), .progRdData(progRdData),
        .progRdValid(progRdValid), .outDrive(outDrive), .outDriveEn(outDriveEn), .busy(busy));
    asr_station u_sta (.clk_sys(clk_sys), .progActive(progActive), .progRdReq(progRdReq),
        .progRdAddr(progRdAddr), .progRdData(progRdData), .progRdValid(progRdValid));

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string msg);
        checked++;
        if (seen !== exp) begin
            badCount++;
            $display("MISMATCH t=%0t %s seen %h exp %h", $time, msg, seen, exp);
        end
    endtask : chk
    task automatic rchk(input logic [3:0] a, input logic [15:0] exp, input string msg);
        logic [15:0] v;
        u_sta.rd(a, v);
        chk(v, exp, msg);
    endtask : rchk
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : tick
    task automatic samp(input logic [15:0] t, input logic [15:0] x, input logic [15:0] y);
        int n;
        n = 0;
        tempSample  = t;
        xSample     = x;
        ySample     = y;
        sampleValid = 1'b1;
        tick(1);
        sampleValid = 1'b0;
        while (busy !== 1'b0 && n < 40) begin
            tick(1);
            n++;
        end
        chk({15'h0000, busy}, 16'h0000, "sample never finished");
    endtask : samp
    task automatic printVerdict();
        $display("comparisons %0d mismatches %0d", checked, badCount);
        if (badCount == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : printVerdict

    initial begin
        #2000000;
        badCount++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        printVerdict();
    end

    initial begin
        {clk_sys, sampleValid, stateMachineTestFail, nvmTestDone, nvmTestFail, romParityFail} = 6'h00;
        {tempSample, xSample, ySample, offsetX, offsetY, phaseCorr} = 96'h0;
        {gainX, gainY} = {16'h4000, 16'h4000};
        {angleZero, lowerFieldThreshold, upperFieldThreshold} = 31'h0;
        rst = 1'b1;
        tick(5);
        rst = 1'b0;
        for (int i = 0; i < 16; i++) rchk(i[3:0], 16'h0000, "reset value");
        $display("test reset done");
        offsetX   = 16'h0064;
        phaseCorr = 16'h4000;
        samp(16'hFFFF, 16'h03E8, 16'hF830);
        rchk(ASR_IDX_TEMP, 16'h7FFF, "temperature code");
        rchk(ASR_IDX_XCOMP, 16'h03E8, "x compensated");
        rchk(ASR_IDX_YCOMP, 16'hF830, "y compensated");
        rchk(ASR_IDX_XANGLE, 16'h044C, "x corrected");
        rchk(ASR_IDX_YANGLE, 16'hFA56, "y corrected");
        $display("test correction done");
        {offsetX, phaseCorr, angleZero} = {16'h0000, 16'h0000, 15'h0100};
        samp(16'h0064, 16'h03E8, 16'h0000);
        u_sta.rd(ASR_IDX_MAG, d);
        chk({15'h0000, d > 16'h060E && d < 16'h06D6}, 16'h0001, "magnitude scale");
        u_sta.rd(ASR_IDX_ANGLE, d);
        chk({15'h0000, d < 16'h0008 || d > 16'h7FF8}, 16'h0001, "angle on x axis");
        d = (outDrive - 16'h0100) & ASR_CODE_MASK;
        chk({15'h0000, d < 16'h0008 || d > 16'h7FF8}, 16'h0001, "output with zero shift");
        rchk(ASR_IDX_FLAGS, 16'h0000, "field in range");
        samp(16'h0064, 16'h0000, 16'h03E8);
        u_sta.rd(ASR_IDX_ANGLE, d);
        chk({15'h0000, d > 16'h1FF8 && d < 16'h2008}, 16'h0001, "angle on y axis");
        samp(16'h0064, 16'hFC18, 16'h0000);
        rchk(ASR_IDX_XANGLE, 16'hFC18, "x corrected negative");
        u_sta.rd(ASR_IDX_ANGLE, d);
        chk({15'h0000, d > 16'h3FF8 && d < 16'h4008}, 16'h0001, "angle on negative x axis");
        $display("test angle done");
        lowerFieldThreshold = 8'h1E;
        samp(16'h0064, 16'h03E8, 16'h0000);
        rchk(ASR_IDX_FLAGS, 16'h0001, "field too low");
        chk(outDrive, ASR_CLAMP_HIGH, "low field clamp");
        {lowerFieldThreshold, upperFieldThreshold} = {8'h00, 8'h7F};
        samp(16'h0064, 16'h03E8, 16'h0000);
        rchk(ASR_IDX_FLAGS, 16'h0002, "field too high");
        chk(outDrive, ASR_CLAMP_HIGH, "high field clamp");
        upperFieldThreshold = 8'h00;
        samp(16'h0064, 16'h03E8, 16'h0000);
        rchk(ASR_IDX_FLAGS, 16'h0000, "range flags follow field");
        $display("test field range done");
        nvmTestFail = 1'b1;
        tick(1);
        nvmTestFail = 1'b0;
        rchk(ASR_IDX_FLAGS, 16'h0000, "memory fail without done");
        stateMachineTestFail = 1'b1;
        tick(1);
        stateMachineTestFail = 1'b0;
        rchk(ASR_IDX_FLAGS, 16'h0020, "state machine fail");
        romParityFail = 1'b1;
        tick(1);
        romParityFail = 1'b0;
        rchk(ASR_IDX_FLAGS, 16'h0028, "parity fail");
        {nvmTestDone, nvmTestFail} = 2'b11;
        tick(1);
        {nvmTestDone, nvmTestFail} = 2'b00;
        rchk(ASR_IDX_FLAGS, 16'h0038, "memory test fail");
        tick(3);
        rchk(ASR_IDX_FLAGS, 16'h0038, "flags sticky");
        chk({15'h0000, outDriveEn}, 16'h0000, "pin yielded to station");
        u_sta.release_pin();
        tick(1);
        chk({15'h0000, outDriveEn}, 16'h0001, "pin driven again");
        rst = 1'b1;
        tick(1);
        rst = 1'b0;
        rchk(ASR_IDX_FLAGS, 16'h0000, "flags cleared by reset");
        $display("test self test done");
        printVerdict();
    end
endmodule : angle_sensor_readout_regs_tb_top
